//--- int_flag_defines.svh
/*
 * Register offsets, field positions and reset values of the external pin
 * interrupt control register and the first peripheral flag register.
 * Assumes inclusion by bare name from any design file that needs them.
 */
`ifndef INT_FLAG_DEFINES_SVH
`define INT_FLAG_DEFINES_SVH

// register indices on the plain register port
`define EXT_CTRL_ADDR 2'h0
`define PFLAGS_ADDR 2'h1
`define REG_ADDR_W 2

// ext_pin_int_control fields
`define EXT_PIN2_PRIO_BIT 7
`define EXT_PIN1_PRIO_BIT 6
`define EXT_PIN2_EN_BIT 4
`define EXT_PIN1_EN_BIT 3
`define EXT_PIN2_FLAG_BIT 1
`define EXT_PIN1_FLAG_BIT 0
`define EXT_CTRL_RESET 8'hC0
`define EXT_PRIO_RESET 2'h3
`define EXT_EN_RESET 2'h0

// periph_int_flags_one fields
`define PF_PARALLEL_BIT 7
`define PF_CONVERTER_BIT 6
`define PF_SERIAL_RX_BIT 5
`define PF_SERIAL_TX_BIT 4
`define PF_SYNC_SERIAL_BIT 3
`define PF_CAPCOMP_BIT 2
`define PF_TIMER_B_BIT 1
`define PF_TIMER_A_BIT 0
`define PFLAGS_RESET 8'h00

`endif

//--- int_flag_pkg.sv
/*
 * Types shared by the interrupt flag block: capture/compare mode encoding,
 * the bundle of peripheral event strobes and the control register layout.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package int_flag_pkg;

	typedef enum logic [2:0] {
		CAPCOMP_CAPTURE = 3'b001,
		CAPCOMP_COMPARE = 3'b010,
		CAPCOMP_PWM = 3'b100
	} capcomp_mode_e;

	// one-cycle strobes and levels from the peripherals, all on the system clock
	typedef struct packed {
		logic parallel_done;
		logic converter_done;
		logic rx_buffer_full;
		logic tx_buffer_empty;
		logic sync_serial_done;
		logic capture_event;
		logic compare_match;
		logic timer_b_match;
		logic timer_a_overflow;
	} periph_events_s;

	typedef struct packed {
		logic pin2_int_priority;
		logic pin1_int_priority;
		logic unused5;
		logic pin2_int_enable;
		logic pin1_int_enable;
		logic unused2;
		logic pin2_int_flag;
		logic pin1_int_flag;
	} ext_ctrl_s;

endpackage

//--- sticky_flags.sv
/*
 * A vector of sticky flags: a set strobe raises a bit, a clear strobe drops
 * it, and a set in the same cycle as a clear wins.
 * Assumes set and clear come from logic on the same clock.
 */
`timescale 1ns/1ps

module sticky_flags #(
	parameter int WIDTH = 8
) (
	// clock and reset
	input wire logic clock,
	input wire logic rst_n,
	// strobes
	input wire logic [WIDTH-1:0] set,
	input wire logic [WIDTH-1:0] clear,
	// state
	output logic [WIDTH-1:0] flags
);

	logic [WIDTH-1:0] next_flags;

	// the set term is or-ed last so an event never loses to a clear
	assign next_flags = (flags & ~clear) | set;

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			flags <= '0;
		end else begin
			flags <= next_flags;
		end
	end

endmodule

//--- pin_edge_sync.sv
/*
 * Brings asynchronous interrupt pins into the clock domain through two
 * flip-flops and reports a one-cycle pulse on each rising edge.
 * Assumes each pin stays at a level for more than one clock period.
 */
`timescale 1ns/1ps

module pin_edge_sync #(
	parameter int WIDTH = 2
) (
	// clock and reset
	input wire logic clock,
	input wire logic rst_n,
	// pins
	input wire logic [WIDTH-1:0] pins,
	// edge pulses
	output logic [WIDTH-1:0] rise
);

	logic [WIDTH-1:0] meta;
	logic [WIDTH-1:0] synced;
	logic [WIDTH-1:0] prev;

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			meta <= '0;
			synced <= '0;
			prev <= '0;
		end else begin
			meta <= pins;
			synced <= meta;
			prev <= synced;
		end
	end

	// edge polarity is fixed to rising; there is no edge selection
	assign rise = synced & ~prev;

endmodule

//--- ext_int_and_periph_flag_regs.sv
/*
 * Flag, enable and priority logic for two external interrupt pins and the
 * first peripheral interrupt flag register, reached over a plain register
 * port with read data one cycle after the read strobe.
 * Assumes peripheral strobes are synchronous one-cycle pulses, the serial
 * buffer states are synchronous levels, and the pins are asynchronous.
 */
// Chosen here: the plain strobed port and the register offsets.
`timescale 1ns/1ps
`include "int_flag_defines.svh"

module ext_int_and_periph_flag_regs #(
	parameter bit HAS_PARALLEL_PORT = 1'b1
) (
	// clock and reset
	input wire logic clock,
	input wire logic arst_n,
	// register port
	input wire logic [`REG_ADDR_W-1:0] addr,
	input wire logic [7:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [7:0] rdata,
	// external interrupt pins, asynchronous
	input wire logic [1:0] int_pins,
	// peripheral events
	input wire int_flag_pkg::periph_events_s events,
	input wire int_flag_pkg::capcomp_mode_e capcomp_mode,
	// toward the processor's interrupt logic
	output logic [7:0] periph_flags,
	output logic [1:0] pin_req,
	output logic high_prio_req,
	output logic low_prio_req
);

	function automatic logic hit(input logic [`REG_ADDR_W-1:0] a,
		input logic [`REG_ADDR_W-1:0] target);
		hit = (a == target);
	endfunction

	// reset release is synchronised; assertion stays asynchronous
	logic rst_meta;
	logic rst_n;

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			rst_meta <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_meta <= 1'b1;
			rst_n <= rst_meta;
		end
	end

	// register decode
	wire sel_ext = hit(addr, `EXT_CTRL_ADDR);
	wire sel_pf = hit(addr, `PFLAGS_ADDR);
	wire wr_ext = wr & sel_ext;
	wire wr_pf = wr & sel_pf;

	// pin flags
	logic [1:0] pin_rise;
	logic [1:0] pin_flag;
	logic [1:0] pin_flag_clear;

	pin_edge_sync #(
		.WIDTH(2)
	) u_pin_sync (
		.clock(clock),
		.rst_n(rst_n),
		.pins(int_pins),
		.rise(pin_rise)
	);

	assign pin_flag_clear[0] = wr_ext & ~wdata[`EXT_PIN1_FLAG_BIT];
	assign pin_flag_clear[1] = wr_ext & ~wdata[`EXT_PIN2_FLAG_BIT];

	// edges set the flags with no look at the enables, so polling works
	sticky_flags #(
		.WIDTH(2)
	) u_pin_flags (
		.clock(clock),
		.rst_n(rst_n),
		.set(pin_rise),
		.clear(pin_flag_clear),
		.flags(pin_flag)
	);

	// pin priority and enable bits
	logic [1:0] pin_prio;
	logic [1:0] pin_en;
	logic [1:0] next_pin_prio;
	logic [1:0] next_pin_en;

	assign next_pin_prio = wr_ext ?
		{wdata[`EXT_PIN2_PRIO_BIT], wdata[`EXT_PIN1_PRIO_BIT]} : pin_prio;
	assign next_pin_en = wr_ext ?
		{wdata[`EXT_PIN2_EN_BIT], wdata[`EXT_PIN1_EN_BIT]} : pin_en;

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			pin_prio <= `EXT_PRIO_RESET;
			pin_en <= `EXT_EN_RESET;
		end else begin
			pin_prio <= next_pin_prio;
			pin_en <= next_pin_en;
		end
	end

	// request routing
	assign pin_req = pin_flag & pin_en;
	assign high_prio_req = |(pin_req & pin_prio);
	assign low_prio_req = |(pin_req & ~pin_prio);

	// peripheral sticky flags, in register order minus the two serial bits
	wire capcomp_hit =
		(capcomp_mode == int_flag_pkg::CAPCOMP_CAPTURE && events.capture_event) ||
		(capcomp_mode == int_flag_pkg::CAPCOMP_COMPARE && events.compare_match);
	logic [5:0] pf_set;
	logic [5:0] pf_clear;
	logic [5:0] pf_sticky;

	assign pf_set = {
		events.parallel_done & HAS_PARALLEL_PORT,
		events.converter_done,
		events.sync_serial_done,
		capcomp_hit,
		events.timer_b_match,
		events.timer_a_overflow
	};
	assign pf_clear = {6{wr_pf}} & ~{wdata[`PF_PARALLEL_BIT], wdata[`PF_CONVERTER_BIT],
		wdata[`PF_SYNC_SERIAL_BIT:`PF_TIMER_A_BIT]};

	sticky_flags #(
		.WIDTH(6)
	) u_periph_flags (
		.clock(clock),
		.rst_n(rst_n),
		.set(pf_set),
		.clear(pf_clear),
		.flags(pf_sticky)
	);

	// serial buffer states mirrored as read-only flags; writes leave them alone
	logic rx_flag;
	logic tx_flag;

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			rx_flag <= 1'b0;
			tx_flag <= 1'b0;
		end else begin
			rx_flag <= events.rx_buffer_full;
			tx_flag <= events.tx_buffer_empty;
		end
	end

	assign periph_flags = {pf_sticky[5:4], rx_flag, tx_flag, pf_sticky[3:0]};

	// read path; unmapped indices read zero
	int_flag_pkg::ext_ctrl_s ext_view;
	logic [7:0] next_rdata;

	assign ext_view = '{
		pin2_int_priority: pin_prio[1],
		pin1_int_priority: pin_prio[0],
		unused5: 1'b0,
		pin2_int_enable: pin_en[1],
		pin1_int_enable: pin_en[0],
		unused2: 1'b0,
		pin2_int_flag: pin_flag[1],
		pin1_int_flag: pin_flag[0]
	};
	assign next_rdata = !rd ? 8'h00 :
		sel_ext ? ext_view :
		sel_pf ? periph_flags : 8'h00;

	// data stands only in the cycle after the strobe
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			rdata <= 8'h00;
		end else begin
			rdata <= next_rdata;
		end
	end

	// checks
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!rst_n);

	a_pin_flag_polled: assert property (
		|(pin_rise & ~pin_en) |=> (pin_flag & $past(pin_rise)) == $past(pin_rise))
		else $error("pin edge with enable off did not set its flag");

	a_pin_flag_hold: assert property (
		pin_flag[1] && !pin_flag_clear[1] |=> pin_flag[1])
		else $error("pin 2 flag dropped without a software clear");

	a_pin_enable_gate: assert property (
		|(pin_flag & ~pin_en) |-> (pin_req & ~pin_en) == 2'b00)
		else $error("pin requested while its enable was clear");

	a_prio_level: assert property (
		pin_req[1] && !pin_prio[1] && !pin_req[0] |-> low_prio_req && !high_prio_req)
		else $error("low priority pin 2 request reached the wrong level");

	a_req_route: assert property (
		pin_flag[0] && pin_en[0] && pin_prio[0] |-> high_prio_req)
		else $error("enabled high priority pin 1 flag gave no request");

	a_parallel_set: assert property (
		events.parallel_done && HAS_PARALLEL_PORT |=> periph_flags[`PF_PARALLEL_BIT])
		else $error("parallel port event did not set its flag");

	a_parallel_absent: assert property (
		!HAS_PARALLEL_PORT |-> !periph_flags[`PF_PARALLEL_BIT])
		else $error("absent parallel port flag read as one");

	a_converter_set: assert property (
		events.converter_done |=> periph_flags[`PF_CONVERTER_BIT] [*2]
		or (periph_flags[`PF_CONVERTER_BIT] ##1 $past(wr_pf)))
		else $error("converter flag did not set or hold");

	a_rx_mirror: assert property (
		##1 periph_flags[`PF_SERIAL_RX_BIT] == $past(events.rx_buffer_full))
		else $error("receive flag does not follow the receive buffer");

	a_tx_mirror: assert property (
		wr_pf && events.tx_buffer_empty == tx_flag |=>
		periph_flags[`PF_SERIAL_TX_BIT] == $past(events.tx_buffer_empty))
		else $error("transmit flag changed by a register write");

	a_sync_serial_set: assert property (
		events.sync_serial_done |=> periph_flags[`PF_SYNC_SERIAL_BIT])
		else $error("sync serial completion did not set its flag");

	a_capture_set: assert property (
		capcomp_mode == int_flag_pkg::CAPCOMP_CAPTURE && events.capture_event
		|=> periph_flags[`PF_CAPCOMP_BIT])
		else $error("capture did not set the capture/compare flag");

	a_compare_set: assert property (
		capcomp_mode == int_flag_pkg::CAPCOMP_COMPARE && events.compare_match
		|=> periph_flags[`PF_CAPCOMP_BIT])
		else $error("compare match did not set the capture/compare flag");

	a_pwm_quiet: assert property (
		capcomp_mode == int_flag_pkg::CAPCOMP_PWM && !periph_flags[`PF_CAPCOMP_BIT]
		|=> !periph_flags[`PF_CAPCOMP_BIT])
		else $error("capture/compare flag set in pwm mode");

	a_timer_b_set: assert property (
		events.timer_b_match |=> periph_flags[`PF_TIMER_B_BIT])
		else $error("timer b match did not set its flag");

	a_timer_a_set: assert property (
		events.timer_a_overflow |=> periph_flags[`PF_TIMER_A_BIT])
		else $error("timer a overflow did not set its flag");

	a_clear_set_wins: assert property (
		wr_pf && !wdata[`PF_TIMER_A_BIT] && events.timer_a_overflow
		|=> periph_flags[`PF_TIMER_A_BIT])
		else $error("event lost to a same-cycle clear");

	a_clear_by_zero: assert property (
		wr_pf && !wdata[`PF_TIMER_B_BIT] && !events.timer_b_match
		|=> !periph_flags[`PF_TIMER_B_BIT])
		else $error("write of zero did not clear the timer b flag");

	a_read_window: assert property (
		rd && sel_ext |=> rdata == $past(ext_view) ##1 ($past(rd) || rdata == 8'h00))
		else $error("read data not in the cycle after the strobe only");

	c_polled_flag: cover property (pin_rise[1] && !pin_en[1] ##1 pin_flag[1]);
	c_set_wins: cover property (wr_pf && !wdata[`PF_CONVERTER_BIT] && events.converter_done);
	c_pwm_event: cover property (capcomp_mode == int_flag_pkg::CAPCOMP_PWM
		&& events.compare_match);
	c_high_req: cover property (high_prio_req && low_prio_req);

endmodule

//--- periph_model.sv
/*
 * Stand-in for the peripherals and pins around the flag block: one-cycle
 * event strobes, serial buffer levels, capture/compare mode and two pins.
 * Assumes the bench calls its tasks from a single process at a time.
 */
`timescale 1ns/1ps

module periph_model (
	// clock
	input wire logic clock,
	// toward the flag block
	output int_flag_pkg::periph_events_s events,
	output int_flag_pkg::capcomp_mode_e capcomp_mode,
	output logic [1:0] int_pins
);
	logic [8:0] strobe = 9'h000;
	logic rx_full = 1'b0;
	logic tx_empty = 1'b1;

	// serial buffer states are levels owned by the serial unit
	assign events = {strobe[8:7], rx_full, tx_empty, strobe[4:0]};

	initial begin
		capcomp_mode = int_flag_pkg::CAPCOMP_CAPTURE;
		int_pins = 2'h0;
	end

	task pulse(input int i);
		@(posedge clock);
		strobe[i] <= 1'b1;
		@(posedge clock);
		strobe[i] <= 1'b0;
	endtask

	// rx full drops when the buffer is read, tx empty drops when it is written
	task serial(input logic rx, input logic tx);
		@(posedge clock);
		rx_full <= rx;
		tx_empty <= tx;
	endtask

	task pin(input int i, input logic v);
		@(posedge clock);
		int_pins[i] <= v;
	endtask

	task mode(input int_flag_pkg::capcomp_mode_e m);
		@(posedge clock);
		capcomp_mode <= m;
	endtask
endmodule

//--- ext_int_and_periph_flag_regs_bench.sv
/*
 * Self-checking bench for the interrupt flag block, with a second copy
 * built without the parallel port.
 * Assumes periph_model drives all peripheral and pin inputs.
 */
`timescale 1ns/1ps
`include "int_flag_defines.svh"

module ext_int_and_periph_flag_regs_bench;
	logic clock = 1'b0;
	logic arst_n = 1'b0;
	logic [1:0] addr = 2'h0;
	logic [7:0] wdata = 8'h00;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic [7:0] rdata;
	logic [7:0] small_flags;
	logic [7:0] periph_flags;
	logic [1:0] int_pins;
	logic [1:0] pin_req;
	logic high_prio_req;
	logic low_prio_req;
	int_flag_pkg::periph_events_s events;
	int_flag_pkg::capcomp_mode_e capcomp_mode;
	int err_total = 0;
	int compares = 0;

	always #5 clock = ~clock;

	periph_model partner_u (.clock(clock), .events(events), .capcomp_mode(capcomp_mode),
		.int_pins(int_pins));

	ext_int_and_periph_flag_regs dut_u (.clock(clock), .arst_n(arst_n), .addr(addr),
		.wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .int_pins(int_pins),
		.events(events), .capcomp_mode(capcomp_mode), .periph_flags(periph_flags),
		.pin_req(pin_req), .high_prio_req(high_prio_req), .low_prio_req(low_prio_req));

	ext_int_and_periph_flag_regs #(.HAS_PARALLEL_PORT(1'b0)) dut_small_u (.clock(clock),
		.arst_n(arst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(),
		.int_pins(int_pins), .events(events), .capcomp_mode(capcomp_mode),
		.periph_flags(small_flags), .pin_req(), .high_prio_req(), .low_prio_req());

	task end_of_test;
		$display("compares %0d mismatches %0d", compares, err_total);
		if (err_total == 0 && compares > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	task check(input logic [7:0] seen, input logic [7:0] exp);
		compares++;
		if (seen !== exp) begin
			err_total++;
			$display("BAD t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task wr_reg(input logic [1:0] a, input logic [7:0] d);
		@(posedge clock);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clock);
		wr <= 1'b0;
	endtask

	task rd_check(input logic [1:0] a, input logic [7:0] exp);
		@(posedge clock);
		addr <= a;
		rd <= 1'b1;
		@(posedge clock);
		rd <= 1'b0;
		#1;
		check(rdata, exp);
	endtask

	task wait_req(input logic [1:0] exp);
		int n;
		n = 0;
		while (pin_req !== exp && n < 8) begin
			@(posedge clock);
			#1;
			n++;
		end
		check({6'h00, pin_req}, {6'h00, exp});
		if (n >= 8) end_of_test();
	endtask

	task t_reset;
		rd_check(`EXT_CTRL_ADDR, `EXT_CTRL_RESET);
		rd_check(`PFLAGS_ADDR, 8'h10);
		wr_reg(2'h2, 8'hff);
		rd_check(2'h2, 8'h00);
		$display("reset values done");
	endtask

	task t_sticky;
		int ev_i[5];
		int fb[5];
		ev_i = '{8, 7, 4, 1, 0};
		fb = '{7, 6, 3, 1, 0};
		for (int k = 0; k < 5; k++) begin
			partner_u.pulse(ev_i[k]);
			rd_check(`PFLAGS_ADDR, 8'h10 | (8'h01 << fb[k]));
			check(periph_flags, 8'h10 | (8'h01 << fb[k]));
			if (k == 0) check(small_flags & 8'h80, 8'h00);
			wr_reg(`PFLAGS_ADDR, 8'hff);
			rd_check(`PFLAGS_ADDR, 8'h10 | (8'h01 << fb[k]));
			wr_reg(`PFLAGS_ADDR, 8'h00);
			rd_check(`PFLAGS_ADDR, 8'h10);
		end
		// a timer event in the clearing cycle must survive the clear
		fork
			partner_u.pulse(0);
			wr_reg(`PFLAGS_ADDR, 8'h00);
		join
		rd_check(`PFLAGS_ADDR, 8'h11);
		wr_reg(`PFLAGS_ADDR, 8'h00);
		$display("sticky flags done");
	endtask

	task t_capcomp;
		int_flag_pkg::capcomp_mode_e md[3];
		md = '{int_flag_pkg::CAPCOMP_CAPTURE, int_flag_pkg::CAPCOMP_COMPARE,
			int_flag_pkg::CAPCOMP_PWM};
		for (int k = 0; k < 3; k++) begin
			partner_u.mode(md[k]);
			partner_u.pulse(3);
			rd_check(`PFLAGS_ADDR, (k == 0) ? 8'h14 : 8'h10);
			wr_reg(`PFLAGS_ADDR, 8'h00);
			partner_u.pulse(2);
			rd_check(`PFLAGS_ADDR, (k == 1) ? 8'h14 : 8'h10);
			wr_reg(`PFLAGS_ADDR, 8'h00);
		end
		$display("capture compare done");
	endtask

	task t_serial;
		partner_u.serial(1'b1, 1'b1);
		rd_check(`PFLAGS_ADDR, 8'h30);
		wr_reg(`PFLAGS_ADDR, 8'h00);
		rd_check(`PFLAGS_ADDR, 8'h30);
		partner_u.serial(1'b0, 1'b1);
		rd_check(`PFLAGS_ADDR, 8'h10);
		partner_u.serial(1'b0, 1'b0);
		rd_check(`PFLAGS_ADDR, 8'h00);
		partner_u.serial(1'b0, 1'b1);
		rd_check(`PFLAGS_ADDR, 8'h10);
		$display("serial levels done");
	endtask

	task t_pins;
		wr_reg(`EXT_CTRL_ADDR, 8'h00);
		wr_reg(`EXT_CTRL_ADDR, 8'h08);
		partner_u.pin(0, 1'b1);
		wait_req(2'b01);
		check({6'h00, high_prio_req, low_prio_req}, 8'h01);
		wr_reg(`EXT_CTRL_ADDR, 8'h49);
		#1;
		check({6'h00, high_prio_req, low_prio_req}, 8'h02);
		partner_u.pin(1, 1'b1);
		repeat (5) @(posedge clock);
		rd_check(`EXT_CTRL_ADDR, 8'h4b);
		check({6'h00, pin_req}, 8'h01);
		wr_reg(`EXT_CTRL_ADDR, 8'hff);
		rd_check(`EXT_CTRL_ADDR, 8'hdb);
		wr_reg(`EXT_CTRL_ADDR, 8'h5b);
		#1;
		check({6'h00, high_prio_req, low_prio_req}, 8'h03);
		wr_reg(`EXT_CTRL_ADDR, 8'h12);
		#1;
		check({6'h00, pin_req}, 8'h02);
		check({6'h00, high_prio_req, low_prio_req}, 8'h01);
		wr_reg(`EXT_CTRL_ADDR, 8'h00);
		rd_check(`EXT_CTRL_ADDR, 8'h00);
		check({6'h00, pin_req}, 8'h00);
		$display("external pins done");
	endtask

	initial begin
		repeat (5) @(posedge clock);
		arst_n <= 1'b1;
		repeat (4) @(posedge clock);
		t_reset();
		t_sticky();
		t_capcomp();
		t_serial();
		t_pins();
		end_of_test();
	end
endmodule
